// ---- core/nso_fifo.sv ----
// small first-in first-out buffer with registered full and empty flags
`timescale 1ns/1ps
module nso_fifo
    import nso_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic   clk,
    input  wire logic   sys_rst,
    input  wire logic   clk_en,
    nso_stream_if.snk   wr_side,
    nso_stream_if.src   rd_side
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_IX  = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ix;
    logic [AW-1:0]    rd_ix;
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;
    logic             space;
    logic             avail;
    logic             push;
    logic             pop;

    // flags are registered so the ready seen outside is a flop
    assign push              = wr_side.valid & space;
    assign pop               = rd_side.ready & avail;
    assign wr_side.ready     = space;
    assign rd_side.valid     = avail;
    assign rd_side.data      = mem[rd_ix];
    assign next_count        = count + CW'(push) - CW'(pop);

    // storage has no reset; only pointers, count and flags carry control state
    always_ff @(posedge clk)
    begin
        if (clk_en && push)
            mem[wr_ix] <= wr_side.data;
    end

    // pointers wrap at depth, not at a power of two
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_ix <= '0;
            rd_ix <= '0;
            count <= '0;
            space <= 1'b1;
            avail <= 1'b0;
        end
        else if (clk_en)
        begin
            if (push)
                wr_ix <= (wr_ix == LAST_IX) ? '0 : wr_ix + AW'(1);
            if (pop)
                rd_ix <= (rd_ix == LAST_IX) ? '0 : rd_ix + AW'(1);
            count <= next_count;
            space <= (next_count != FULL_CNT);
            avail <= (next_count != '0);
        end
    end
endmodule

// ---- core/nso_nav_io.sv ----
// serial navigation listeners, talker and open-drain status outputs
// Contract
// RULE1: one second tick on its own output
// RULE2: tick spends half period low, half released
// RULE3: work flag low in normal, open in work
// RULE4: speed flag low for low-speed parameters; code drives it low only when heading_mode is also high
// RULE5: all three outputs open-drain, never drive high
// RULE6: serial traffic defaults to 4800 baud
// RULE7: eight data bits, no parity, one stop
// RULE8: optional checksum verified when present
// RULE9: second listener finds its rate automatically
// RULE10: least significant bit sent first
// RULE11: start bit zero, stop bit one
// RULE12: line idles at logical one
// RULE13: talker A inverted, B true
// RULE14: malformed sentences are treated as invalid
// RULE15: talker sends heading and status sentences
// RULE16: two independent listener ports
// RULE17: activity toggles on every received character
// RULE18: port one fixed; port two relocks after quiet
// RULE19: mid-bit sampling, framing and checksum events
`timescale 1ns/1ps
module nso_nav_io
    import nso_pkg::*;
#(
    parameter int BIT_CYC_DEFAULT = CYC_BIT_DEFAULT,
    parameter int BIT_CYC_ALT     = CYC_BIT_ALT,
    parameter int TICK_HALF       = TICK_HALF_CYC,
    parameter int LOCK_QUIET      = LOCK_QUIET_CYC,
    parameter int TX_DEPTH        = FIFO_DEPTH
)(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic [1:0]  listener_rx,
    output logic [1:0][7:0]  rx_char,
    output logic [1:0]       rx_char_valid,
    output logic [1:0]       rx_activity,
    output logic [1:0]       framing_err,
    output logic [1:0]       checksum_err,
    output logic [1:0]       sentence_ok,
    output logic [1:0]       sentence_bad,
    output logic             port_two_fast,
    output logic             port_two_locked,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    output logic             talker_a,
    output logic             talker_b,
    input  wire logic        work_mode_engaged,
    input  wire logic        heading_mode,
    input  wire logic        low_speed_params,
    output logic             second_tick_output,
    output logic             second_tick_oe_n,
    output logic             work_mode_out,
    output logic             work_mode_oe_n,
    output logic             fast_steering_indicator,
    output logic             fast_steering_oe_n
);

    // ********************
    // helpers
    // ********************
    function automatic logic is_hex(input logic [7:0] c);
        return ((c >= CH_D0) && (c <= CH_D9)) || ((c >= CH_UA) && (c <= CH_UF));
    endfunction

    function automatic logic [3:0] hex_val(input logic [7:0] c);
        logic [7:0] v;
        v = (c <= CH_D9) ? (c - CH_D0) : (c - CH_ATEN);
        return v[3:0];
    endfunction

    function automatic logic is_end(input logic [7:0] c);
        return (c == CH_CR) || (c == CH_LF);
    endfunction

    localparam logic [31:0] TICK_LAST  = 32'(TICK_HALF - 1);
    localparam logic [31:0] QUIET_LAST = 32'(LOCK_QUIET - 1);
    localparam logic [31:0] TXB_LAST   = 32'(BIT_CYC_DEFAULT - 1);
    localparam logic [2:0]  LAST_BIT   = 3'(DATA_BITS - 1);

    // ********************
    // listeners
    // ********************
    logic [1:0] ch_stb;
    logic [1:0] fr_stb;

    // independent receiver and checker per port [RULE16]
    for (genvar p = 0; p < 2; p++)
    begin : g_listen
        nso_rx_st_t  rx_st;
        nso_sen_st_t sen_st;
        logic [31:0] cnt;
        logic [31:0] bit_last;
        logic [31:0] half_last;
        logic [2:0]  bit_ix;
        logic [7:0]  shreg;
        logic [7:0]  sum;
        logic [3:0]  hi_nib;
        logic        sum_match;
        logic [7:0]  c;

        // port one never leaves the default rate [RULE18] [RULE6]
        assign bit_last  = (p == 1 && port_two_fast) ? 32'(BIT_CYC_ALT - 1) : 32'(BIT_CYC_DEFAULT - 1); // [RULE9]
        assign half_last = {1'b0, bit_last[31:1]};
        assign c         = rx_char[p];

        // start confirmed at half bit, so data lands mid-bit
        always_ff @(posedge clk)
        begin
            if (sys_rst)
            begin
                rx_st         <= RX_IDLE;
                cnt           <= '0;
                bit_ix        <= '0;
                shreg         <= '0;
                rx_char[p]    <= '0;
                ch_stb[p]     <= 1'b0;
                fr_stb[p]     <= 1'b0;
                rx_activity[p] <= 1'b0;
            end
            else if (clk_en)
            begin
                ch_stb[p] <= 1'b0;
                fr_stb[p] <= 1'b0;
                unique case (rx_st)
                    RX_IDLE:
                    begin
                        cnt <= '0;
                        if (listener_rx[p] == START_BIT) // [RULE12] [RULE11]
                            rx_st <= RX_START;
                    end
                    RX_START:
                    begin
                        cnt <= cnt + 32'd1;
                        if (cnt == half_last)
                        begin
                            cnt    <= '0;
                            bit_ix <= '0;
                            // a short glitch back to idle is not a start
                            rx_st  <= (listener_rx[p] == START_BIT) ? RX_DATA : RX_IDLE; // [RULE19]
                        end
                    end
                    RX_DATA:
                    begin
                        cnt <= cnt + 32'd1;
                        if (cnt == bit_last)
                        begin
                            cnt    <= '0;
                            shreg  <= {listener_rx[p], shreg[7:1]}; // [RULE10] [RULE7]
                            bit_ix <= bit_ix + 3'd1;
                            if (bit_ix == LAST_BIT)
                                rx_st <= RX_STOP; // no parity slot [RULE7]
                        end
                    end
                    RX_STOP:
                    begin
                        cnt <= cnt + 32'd1;
                        if (cnt == bit_last)
                        begin
                            rx_st          <= RX_IDLE;
                            rx_activity[p] <= ~rx_activity[p]; // [RULE17]
                            if (listener_rx[p] == STOP_BIT) // [RULE11]
                            begin
                                rx_char[p] <= shreg;
                                ch_stb[p]  <= 1'b1;
                            end
                            else
                                fr_stb[p]  <= 1'b1; // [RULE19]
                        end
                    end
                endcase
            end
        end

        assign rx_char_valid[p] = ch_stb[p];
        assign framing_err[p]   = fr_stb[p];

        // sentence checker works on the character strobe one cycle later
        always_ff @(posedge clk)
        begin
            if (sys_rst)
            begin
                sen_st          <= SEN_HUNT;
                sum             <= '0;
                hi_nib          <= '0;
                sum_match       <= 1'b0;
                sentence_ok[p]  <= 1'b0;
                sentence_bad[p] <= 1'b0;
                checksum_err[p] <= 1'b0;
            end
            else if (clk_en)
            begin
                sentence_ok[p]  <= 1'b0;
                sentence_bad[p] <= 1'b0;
                checksum_err[p] <= 1'b0;
                if (fr_stb[p] && sen_st != SEN_HUNT)
                begin
                    sentence_bad[p] <= 1'b1; // broken character spoils the sentence
                    sen_st          <= SEN_HUNT;
                end
                else if (ch_stb[p])
                begin
                    unique case (sen_st)
                        SEN_HUNT:
                        begin
                            sum <= '0;
                            if (c == CH_DOLLAR || c == CH_BANG)
                                sen_st <= SEN_BODY;
                        end
                        SEN_BODY:
                        begin
                            if (c == CH_STAR)
                                sen_st <= SEN_SUM1;
                            else if (is_end(c))
                            begin
                                sentence_ok[p] <= 1'b1; // no checksum is accepted [RULE8]
                                sen_st         <= SEN_HUNT;
                            end
                            else if (c < CH_PR_LO || c > CH_PR_HI || c == CH_DOLLAR || c == CH_BANG)
                            begin
                                sentence_bad[p] <= 1'b1; // [RULE14]
                                sen_st          <= SEN_HUNT;
                            end
                            else
                                sum <= sum ^ c;
                        end
                        SEN_SUM1:
                        begin
                            hi_nib <= hex_val(c);
                            if (!is_hex(c))
                            begin
                                sentence_bad[p] <= 1'b1; // [RULE14]
                                sen_st          <= SEN_HUNT;
                            end
                            else
                                sen_st <= SEN_SUM2;
                        end
                        SEN_SUM2:
                        begin
                            sum_match <= ({hi_nib, hex_val(c)} == sum);
                            if (!is_hex(c))
                            begin
                                sentence_bad[p] <= 1'b1; // [RULE14]
                                sen_st          <= SEN_HUNT;
                            end
                            else
                                sen_st <= SEN_END;
                        end
                        SEN_END:
                        begin
                            sen_st <= SEN_HUNT;
                            if (is_end(c) && sum_match)
                                sentence_ok[p] <= 1'b1;
                            else
                            begin
                                sentence_bad[p] <= 1'b1;
                                checksum_err[p] <= is_end(c); // [RULE8] [RULE19]
                            end
                        end
                        default:
                            sen_st <= SEN_HUNT;
                    endcase
                end
            end
        end
    end

    // ********************
    // rate search for port two
    // ********************
    logic [31:0] quiet_cnt;

    // locked on a good sentence; any error while searching flips the rate
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            port_two_fast   <= 1'b0;
            port_two_locked <= 1'b0;
            quiet_cnt       <= '0;
        end
        else if (clk_en)
        begin
            if (sentence_ok[1])
            begin
                port_two_locked <= 1'b1; // [RULE9]
                quiet_cnt       <= '0;
            end
            else if (port_two_locked)
            begin
                quiet_cnt <= quiet_cnt + 32'd1;
                if (quiet_cnt == QUIET_LAST)
                    port_two_locked <= 1'b0; // [RULE18]
            end
            else if (framing_err[1] || sentence_bad[1])
                port_two_fast <= ~port_two_fast; // [RULE9]
        end
    end

    // ********************
    // talker
    // ********************
    nso_stream_if #(.WIDTH(8)) tx_in ();
    nso_stream_if #(.WIDTH(8)) tx_out ();

    assign tx_in.data  = tx_data;
    assign tx_in.valid = tx_valid;
    assign tx_ready    = tx_in.ready;

    // producer may run ahead of the line
    nso_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .wr_side (tx_in.snk),
        .rd_side (tx_out.src)
    );

    nso_tx_st_t  tx_st;
    logic [31:0] tx_cnt;
    logic [2:0]  tx_ix;
    logic [7:0]  tx_sh;

    assign tx_out.ready = (tx_st == TX_IDLE);

    // talker at fixed default rate [RULE15]
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tx_st    <= TX_IDLE;
            tx_cnt   <= '0;
            tx_ix    <= '0;
            tx_sh    <= '0;
            talker_a <= ~IDLE_LEVEL;
            talker_b <= IDLE_LEVEL;
        end
        else if (clk_en)
        begin
            tx_cnt <= tx_cnt + 32'd1;
            unique case (tx_st)
                TX_IDLE:
                begin
                    tx_cnt   <= '0;
                    talker_a <= ~IDLE_LEVEL; // [RULE12] [RULE13]
                    talker_b <= IDLE_LEVEL;
                    if (tx_out.valid)
                    begin
                        tx_sh    <= tx_out.data;
                        tx_st    <= TX_START;
                        talker_a <= ~START_BIT; // [RULE11] [RULE13]
                        talker_b <= START_BIT;
                    end
                end
                TX_START:
                begin
                    if (tx_cnt == TXB_LAST) // [RULE6]
                    begin
                        tx_cnt   <= '0;
                        tx_ix    <= '0;
                        tx_st    <= TX_DATA;
                        talker_a <= ~tx_sh[0]; // [RULE10] [RULE13]
                        talker_b <= tx_sh[0];
                    end
                end
                TX_DATA:
                begin
                    if (tx_cnt == TXB_LAST)
                    begin
                        tx_cnt <= '0;
                        tx_ix  <= tx_ix + 3'd1;
                        if (tx_ix == LAST_BIT)
                        begin
                            tx_st    <= TX_STOP; // [RULE7]
                            talker_a <= ~STOP_BIT;
                            talker_b <= STOP_BIT;
                        end
                        else
                        begin
                            talker_a <= ~tx_sh[tx_ix + 3'd1]; // [RULE10]
                            talker_b <= tx_sh[tx_ix + 3'd1];
                        end
                    end
                end
                TX_STOP:
                begin
                    if (tx_cnt == TXB_LAST)
                        tx_st <= TX_IDLE; // idle level already on the line
                end
            endcase
        end
    end

    // ********************
    // open-drain status and tick outputs
    // ********************
    logic [31:0] tick_cnt;

    // pin data is a constant low flop; only enables move [RULE5]
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            second_tick_output      <= OD_LOW;
            work_mode_out           <= OD_LOW;
            fast_steering_indicator <= OD_LOW;
        end
    end

    // exact count, well inside the allowed drift
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tick_cnt         <= '0;
            second_tick_oe_n <= 1'b0;
        end
        else if (clk_en)
        begin
            tick_cnt <= tick_cnt + 32'd1;
            if (tick_cnt == TICK_LAST) // [RULE1]
            begin
                tick_cnt         <= '0;
                second_tick_oe_n <= ~second_tick_oe_n; // [RULE2]
            end
        end
    end

    // status flags follow their inputs one cycle late
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            work_mode_oe_n     <= 1'b0;
            fast_steering_oe_n <= 1'b1;
        end
        else if (clk_en)
        begin
            work_mode_oe_n     <= work_mode_engaged; // [RULE3]
            fast_steering_oe_n <= ~(heading_mode & low_speed_params); // [RULE4]
        end
    end
endmodule

// ---- inc/nso_pkg.sv ----
// constants shared by the navigation serial and status output block
package nso_pkg;

    // ********************
    // clock and timing
    // ********************
    localparam int CLK_HZ          = 250_000_000;
    localparam int BAUD_DEFAULT    = 4800;
    localparam int BAUD_ALT        = 9600;
    localparam int CYC_BIT_DEFAULT = CLK_HZ / BAUD_DEFAULT;
    localparam int CYC_BIT_ALT     = CLK_HZ / BAUD_ALT;
    localparam int TICK_PERIOD_S   = 1;
    localparam int TICK_HALF_CYC   = (CLK_HZ / 2) * TICK_PERIOD_S;
    localparam int LOCK_QUIET_MS   = 3000;
    localparam int LOCK_QUIET_CYC  = (CLK_HZ / 1000) * LOCK_QUIET_MS;

    // ********************
    // character framing, talker buffer depth and open-drain level
    // ********************
    localparam int       DATA_BITS  = 8;
    localparam logic     START_BIT  = 1'b0;
    localparam logic     STOP_BIT   = 1'b1;
    localparam logic     IDLE_LEVEL = 1'b1;
    localparam int       FIFO_DEPTH = 8;
    localparam logic     OD_LOW     = 1'b0;

    // ********************
    // sentence characters
    // ********************
    localparam logic [7:0] CH_DOLLAR = 8'h24;
    localparam logic [7:0] CH_BANG   = 8'h21;
    localparam logic [7:0] CH_STAR   = 8'h2a;
    localparam logic [7:0] CH_CR     = 8'h0d;
    localparam logic [7:0] CH_LF     = 8'h0a;
    localparam logic [7:0] CH_PR_LO  = 8'h20;
    localparam logic [7:0] CH_PR_HI  = 8'h7e;
    localparam logic [7:0] CH_D0     = 8'h30;
    localparam logic [7:0] CH_D9     = 8'h39;
    localparam logic [7:0] CH_UA     = 8'h41;
    localparam logic [7:0] CH_UF     = 8'h46;
    localparam logic [7:0] CH_ATEN   = 8'h37;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} nso_rx_st_t;
    typedef enum logic [2:0] {SEN_HUNT, SEN_BODY, SEN_SUM1, SEN_SUM2, SEN_END} nso_sen_st_t;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} nso_tx_st_t;

endpackage

// ---- inc/nso_stream_if.sv ----
// valid/ready character stream between the block's own modules
`timescale 1ns/1ps
interface nso_stream_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

// ---- tb/nso_nav_io_checker.sv ----
// assertions on the navigation io top ports
`timescale 1ns/1ps
module nso_nav_io_checker
#(
    parameter int TICK_HALF       = 50,
    parameter int BIT_CYC_DEFAULT = 16
)(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic [1:0] rx_char_valid,
    input wire logic [1:0] rx_activity,
    input wire logic [1:0] framing_err,
    input wire logic       talker_a,
    input wire logic       talker_b,
    input wire logic       work_mode_engaged,
    input wire logic       heading_mode,
    input wire logic       low_speed_params,
    input wire logic       second_tick_oe_n,
    input wire logic       work_mode_oe_n,
    input wire logic       fast_steering_oe_n
);
    localparam int B = BIT_CYC_DEFAULT;
    int fcnt; // cycles into a talker frame, 0 when idle
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ****
    // frame position: a fall seen while idle opens a frame
    // ****
    always_ff @(posedge clk)
        if (sys_rst || fcnt == 10 * B - 1)
            fcnt <= 0;
        else if (fcnt != 0 || !talker_b)
            fcnt <= fcnt + 1;
    sequence s_flip;
        $changed(second_tick_oe_n);
    endsequence
    property p_tick; s_flip |-> ##TICK_HALF s_flip; endproperty
    a_tick: assert property (p_tick) else $error("tick half period");
    property p_work; work_mode_oe_n == $past(work_mode_engaged); endproperty
    a_work: assert property (p_work) else $error("work flag");
    property p_speed; fast_steering_oe_n == !$past(heading_mode && low_speed_params); endproperty
    a_speed: assert property (p_speed) else $error("speed flag");
    property p_pair; talker_a == !talker_b; endproperty
    a_pair: assert property (p_pair) else $error("talker pair");
    property p_start; fcnt > 0 && fcnt < B |-> !talker_b; endproperty
    a_start: assert property (p_start) else $error("start bit");
    property p_stop; fcnt >= 9 * B |-> talker_b; endproperty
    a_stop: assert property (p_stop) else $error("stop bit");
    property p_idle; fcnt == 10 * B - 1 |=> talker_b; endproperty
    a_idle: assert property (p_idle) else $error("idle gap");
    property p_act; (rx_activity ^ $past(rx_activity)) == (rx_char_valid | framing_err); endproperty
    a_act: assert property (p_act) else $error("activity toggle");
endmodule

// ---- tb/nso_nav_io_tb.sv ----
// self-checking bench for the navigation serial and status block
`timescale 1ns/1ps
module nso_nav_io_tb;
    import nso_pkg::*;
    localparam int TICK_HALF = 50;
    localparam int BIT_CYC_DEFAULT = 16;
    localparam int BA = 8;
    logic            clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, tx_valid = 1'b0;
    logic            work_mode_engaged = 1'b0, heading_mode = 1'b0, low_speed_params = 1'b0;
    logic [7:0]      tx_data = 8'h30;
    logic [1:0]      listener_rx, rx_char_valid, rx_activity, framing_err, checksum_err, sentence_ok, sentence_bad;
    logic [1:0][7:0] rx_char;
    logic            port_two_fast, port_two_locked, tx_ready, talker_a, talker_b, second_tick_output;
    logic            second_tick_oe_n, work_mode_out, work_mode_oe_n, fast_steering_indicator, fast_steering_oe_n;
    int              miscompares = 0, cmp_count = 0, n_ok[2], n_bad[2], n_ck[2], n_fe[2];
    nso_nav_io #(.BIT_CYC_DEFAULT(16), .BIT_CYC_ALT(BA), .TICK_HALF(TICK_HALF), .LOCK_QUIET(2000)) dut (.*);
    nso_nav_partner #(.BIT(16)) pp (.clk(clk), .talker_b(talker_b), .listener_rx(listener_rx));
    always #2 clk = ~clk;
    // ****
    // event counts per listener port
    // ****
    always @(posedge clk)
        for (int i = 0; i < 2; i++)
        begin
            n_ok[i] += sentence_ok[i];
            n_bad[i] += sentence_bad[i];
            n_ck[i] += checksum_err[i];
            n_fe[i] += framing_err[i];
        end
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // sentence plus CR, then a gap
    task automatic sentence(input int p, input string s, input int bc);
        for (int i = 0; i < s.len(); i++)
            pp.send(p, s[i], bc, 1'b1);
        pp.send(p, CH_CR, bc, 1'b1);
        repeat (4 * bc) @(posedge clk);
    endtask
    task automatic t_status();
        for (int k = 0; k < 8; k++)
        begin
            {work_mode_engaged, heading_mode, low_speed_params} <= k[2:0];
            repeat (2) step();
            chk("work_oe_n", k[2], work_mode_oe_n);
            chk("speed_oe_n", !(k[1] && k[0]), fast_steering_oe_n);
            chk("od_data", 0, {second_tick_output, work_mode_out, fast_steering_indicator});
        end
    endtask
    task automatic t_tick();
        logic v;
        int   n;
        for (int k = 0; k < 3; k++)
        begin
            v = second_tick_oe_n;
            for (n = 0; n < 3 * TICK_HALF && second_tick_oe_n === v; n++)
                step();
            if (k > 0)
                chk("tick_half", TICK_HALF, n);
        end
    endtask
    task automatic t_rx();
        sentence(0, "$A*41", 16);
        sentence(0, "$AB", 16);
        sentence(0, "$A*40", 16);
        sentence(0, "$A\001", 16);
        pp.send(0, 8'h55, 16, 1'b0);
        repeat (64) step();
        chk("ok0", 2, n_ok[0]);
        chk("cks0", 1, n_ck[0]);
        chk("bad0", 2, n_bad[0]);
        chk("frm0", 1, n_fe[0]);
        chk("char0", CH_CR, rx_char[0]);
        chk("quiet1", 0, n_ok[1] + n_bad[1] + n_fe[1]);
    endtask
    task automatic t_rate();
        chk("slow", 0, port_two_fast);
        pp.send(1, 8'h00, 16, 1'b0);
        repeat (160) step();
        chk("fast", 1, port_two_fast);
        sentence(1, "$A*41", BA);
        chk("lock", 1, port_two_locked);
        sentence(0, "$A*41", BA);
        chk("p1_fixed", 2, n_ok[0]);
        repeat (2100) step();
        chk("unlock", 0, port_two_locked);
    endtask
    task automatic t_tx();
        int   n;
        logic r;
        n = 0;
        chk("idle_b", 1, talker_b);
        tx_valid <= 1'b1;
        for (int i = 0; i < 20; i++)
        begin
            r = tx_ready; // settled value the coming edge acts on
            step();
            if (r === 1'b1)
            begin
                n++;
                tx_data <= 8'h30 + n[7:0];
            end
        end
        tx_valid <= 1'b0;
        chk("fill", FIFO_DEPTH + 1, n);
        for (int i = 0; i < 4000 && pp.heard.size() < n; i++)
            step();
        for (int i = 0; i < n; i++)
            chk("heard", 8'h30 + i[7:0], pp.heard[i]);
        chk("frames", n, pp.heard.size() + pp.bad);
        chk("drained", 1, tx_ready);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        step();
        t_status();
        t_tick();
        t_rx();
        t_rate();
        t_tx();
        report_and_stop();
    end
endmodule
bind nso_nav_io nso_nav_io_checker #(.TICK_HALF(TICK_HALF), .BIT_CYC_DEFAULT(BIT_CYC_DEFAULT)) u_chk (.*);

// ---- tb/nso_nav_partner.sv ----
// far-side instruments: two senders and a listener on talker b of the talker pair
`timescale 1ns/1ps
module nso_nav_partner
#(parameter int BIT = 16)(
    input  wire logic       clk,
    input  wire logic       talker_b,
    output logic      [1:0] listener_rx
);
    logic [7:0] heard[$];
    logic [7:0] sh;
    int         bad = 0;
    initial listener_rx = 2'b11; // lines rest at mark
    // one character; stp low forces a framing fault
    task automatic send(input int p, input logic [7:0] c, input int bc, input logic stp);
        logic [9:0] f;
        f = {stp, c, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            listener_rx[p] <= f[i];
            repeat (bc) @(posedge clk);
        end
        if (!stp)
            listener_rx[p] <= 1'b1;
    endtask
    // listener: b carries the true level, sampled mid-bit
    always
    begin
        @(negedge talker_b);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT) @(posedge clk);
            sh[i] = talker_b;
        end
        repeat (BIT) @(posedge clk);
        if (talker_b !== 1'b1)
            bad++;
        heard.push_back(sh);
    end
endmodule
